// file: core/counter_array_pkg.sv
// Types shared by the counter array watchdog files.
// Assumes nothing beyond a SystemVerilog compiler.
package counter_array_pkg;

  // One register access from the processor.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_s;

  // Control and flag register, laid out as read.
  typedef struct packed {
    logic cf;
    logic cr;
    logic [2:0] rsvd;
    logic [2:0] ccf;
  } ctrl_s;

  // Mode register, laid out as read.
  typedef struct packed {
    logic idle_suspend_bit;
    logic watchdog_enable_bit;
    logic watchdog_lock_bit;
    logic rsvd;
    logic [2:0] cps;
    logic ecf;
  } mode_s;

endpackage

// file: core/counter_array_regs.svh
// Register addresses, reset values and divider counts for the counter array watchdog.
// Assumes inclusion by bare name from files under core/.
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

// Special function register addresses.
`define CA_ADDR_CTRL 8'hD8
`define CA_ADDR_MODE 8'hD9
`define CA_ADDR_MOD2_MODE 8'hDC
`define CA_ADDR_CNT_LOW 8'hE9
`define CA_ADDR_OFFSET 8'hEB
`define CA_ADDR_CNT_HIGH 8'hF9
`define CA_ADDR_CMP_HIGH 8'hFB

// Reset values.
`define CA_RST_CTRL 8'h00
`define CA_RST_MODE 8'h40
`define CA_RST_BYTE 8'h00
`define CA_RST_CNT 16'h0000

// Bit positions inside written bytes.
`define CA_BIT_MODULE2_MATCH_FLAG 2
`define CA_BIT_WATCHDOG_ENABLE_BIT 6
`define CA_BIT_WATCHDOG_LOCK_BIT 5

// Clock source select codes.
`define CA_CPS_DIV12 3'h0
`define CA_CPS_DIV4 3'h1
`define CA_CPS_EXT 3'h2
`define CA_CPS_SYSTEM_CLOCK 3'h4

// Divider counts, in system clock cycles per counter clock.
`define CA_SYSDIV_SLOW 12
`define CA_SYSDIV_MID 4

// Default timeout: counter clocks and system clock cycles.
`define CA_WD_DEFAULT_TICKS 256
`define CA_WD_DEFAULT_CYCLES (`CA_WD_DEFAULT_TICKS * `CA_SYSDIV_SLOW)

`endif

// file: core/counter_array_watchdog.sv
// Counter array core with its watchdog on compare module 2, plus control, mode and data registers.
// Assumes a single-cycle register write port synchronous to clk and an external reset controller
// that turns watchdog_reset into a system reset on rst_b.
//
// How it works
// - Reset when low byte overflows while compare high matches counter high, watchdog on.
// - Writing 1 to module 2 flag while watchdog on forces a reset.
// - While watchdog on, clock select and idle suspend bits ignore writes.
// - Watchdog is active when enable bit or lock bit is set.
// - Lock bit cannot be cleared by software; only reset clears it.
// - With lock clear, clearing the enable bit disables the watchdog.
// - Reset gives watchdog on, divide-by-12 clock, counter low and offset zero.
// - Reset defaults time out 256 counter clocks, 3072 system clocks, after reset.
// - With idle suspend set, counting pauses while the processor idles.
// - Counter wrap sets overflow flag; it may interrupt; software clears it.
// - Run bit 6 of the control register stops or runs the counter.
// - Control bits 5 to 3 read zero and ignore writes.
// - Module flags set on match (module 2 only with watchdog off), may interrupt, cleared only by software.
// - A compare high write with watchdog on refreshes: loads counter high plus offset.
// - Offset counts low-byte overflows; timeout is 256 times offset plus remainder.
// - Watchdog on forces counter running and blocks counter and module 2 mode writes.
`include "counter_array_regs.svh"
module counter_array_watchdog #(
  parameter int DIV_SLOW = `CA_SYSDIV_SLOW
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire counter_array_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // Processor state and counter clock source.
  input wire logic cpu_idle,
  input wire logic ext_tick,
  // Match or capture events and interrupt enables of modules 0 to 2.
  input wire logic [2:0] module_match,
  input wire logic [2:0] module_int_en,
  // Interrupt request and watchdog reset request.
  output logic counter_irq,
  output logic watchdog_reset
);
  import counter_array_pkg::*;

  ctrl_s ctrl_r;
  ctrl_s ctrl_nxt;
  mode_s mode_r;
  mode_s mode_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [7:0] cmp_high_r;
  logic [7:0] cmp_high_nxt;
  logic [7:0] offset_r;
  logic [7:0] offset_nxt;
  logic [7:0] mod2_mode_r;
  logic [7:0] mod2_mode_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wdrst_r;
  logic wdrst_nxt;
  logic pre_tick;
  logic wd_active;
  logic run;
  logic tick;
  logic wrap;
  logic low_ovf;
  logic wd_hit;
  logic wd_force;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic wr_cmp_high;
  logic wr_offset;
  logic wr_mod2_mode;
  logic [16:0] wd_ticks_r;
  logic [16:0] wd_ticks_nxt;
  logic [16:0] wd_limit_r;
  logic [16:0] wd_limit_nxt;
  logic wd_track_r;
  logic wd_track_nxt;

  // Counter clock enable from the selected source.
  counter_prescaler #(
    .DIV_SLOW(DIV_SLOW)
  ) u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .sel(mode_r.cps),
    .ext_tick(ext_tick),
    .tick(pre_tick)
  );

  // Address decode of the single-cycle write strobe.
  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `CA_ADDR_CTRL);
  assign wr_mode = sfr_req.wr && (sfr_req.addr == `CA_ADDR_MODE);
  assign wr_cnt_low = sfr_req.wr && (sfr_req.addr == `CA_ADDR_CNT_LOW);
  assign wr_cnt_high = sfr_req.wr && (sfr_req.addr == `CA_ADDR_CNT_HIGH);
  assign wr_cmp_high = sfr_req.wr && (sfr_req.addr == `CA_ADDR_CMP_HIGH);
  assign wr_offset = sfr_req.wr && (sfr_req.addr == `CA_ADDR_OFFSET);
  assign wr_mod2_mode = sfr_req.wr && (sfr_req.addr == `CA_ADDR_MOD2_MODE);

  // Watchdog state and counter events.
  assign wd_active = mode_r.watchdog_enable_bit | mode_r.watchdog_lock_bit;
  assign run = ctrl_r.cr | wd_active;
  assign tick = pre_tick && run && !(mode_r.idle_suspend_bit && cpu_idle);
  assign wrap = tick && (cnt_r == 16'hFFFF);
  assign low_ovf = tick && (cnt_r[7:0] == 8'hFF);
  assign wd_hit = wd_active && low_ovf && (cmp_high_r == cnt_r[15:8]);
  assign wd_force = wd_active && wr_ctrl && sfr_req.wdata[`CA_BIT_MODULE2_MATCH_FLAG];

  // Control register: software writes first, then hardware sets win over a same-cycle clear.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = ctrl_s'(sfr_req.wdata);
    end
    ctrl_nxt.rsvd = 3'h0;
    if (wrap) begin
      ctrl_nxt.cf = 1'b1;
    end
    // Module 2 is a plain timer while the watchdog owns it, so its match is not flagged then.
    ctrl_nxt.ccf = ctrl_nxt.ccf | (module_match & {!wd_active, 2'h3});
  end

  // Mode register: clock select and idle suspend freeze while the watchdog runs.
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt.ecf = sfr_req.wdata[0];
      mode_nxt.watchdog_enable_bit = sfr_req.wdata[`CA_BIT_WATCHDOG_ENABLE_BIT];
      mode_nxt.watchdog_lock_bit = mode_r.watchdog_lock_bit | sfr_req.wdata[`CA_BIT_WATCHDOG_LOCK_BIT];
      if (!wd_active) begin
        mode_nxt.idle_suspend_bit = sfr_req.wdata[7];
        mode_nxt.cps = sfr_req.wdata[3:1];
      end
    end
    mode_nxt.rsvd = 1'b0;
  end

  // Counter and module 2 bytes; a software write to a counter byte beats a same-cycle tick.
  always_comb begin
    cnt_nxt = tick ? cnt_r + 16'h0001 : cnt_r;
    if (wr_cnt_low && !wd_active) begin
      cnt_nxt[7:0] = sfr_req.wdata;
    end
    if (wr_cnt_high && !wd_active) begin
      cnt_nxt[15:8] = sfr_req.wdata;
    end
    offset_nxt = wr_offset ? sfr_req.wdata : offset_r;
    mod2_mode_nxt = (wr_mod2_mode && !wd_active) ? sfr_req.wdata : mod2_mode_r;
    cmp_high_nxt = cmp_high_r;
    if (wr_cmp_high) begin
      // The written value is discarded on a refresh; only the deadline matters.
      cmp_high_nxt = wd_active ? 8'(cnt_r[15:8] + offset_r) : sfr_req.wdata;
    end
  end

  // Read data, interrupt request and watchdog reset request, all registered.
  always_comb begin
    case (sfr_req.addr)
      `CA_ADDR_CTRL: rdata_nxt = ctrl_r;
      `CA_ADDR_MODE: rdata_nxt = mode_r;
      `CA_ADDR_MOD2_MODE: rdata_nxt = mod2_mode_r;
      `CA_ADDR_CNT_LOW: rdata_nxt = cnt_r[7:0];
      `CA_ADDR_CNT_HIGH: rdata_nxt = cnt_r[15:8];
      `CA_ADDR_OFFSET: rdata_nxt = offset_r;
      `CA_ADDR_CMP_HIGH: rdata_nxt = cmp_high_r;
      default: rdata_nxt = 8'h00;
    endcase
    irq_nxt = (ctrl_r.cf && mode_r.ecf) || |(ctrl_r.ccf & module_int_en);
    wdrst_nxt = wd_hit || wd_force;
  end

  // Registers; reset brings the watchdog up enabled on the divide-by-12 clock.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= ctrl_s'(`CA_RST_CTRL);
      mode_r <= mode_s'(`CA_RST_MODE);
      cnt_r <= `CA_RST_CNT;
      cmp_high_r <= `CA_RST_BYTE;
      offset_r <= `CA_RST_BYTE;
      mod2_mode_r <= `CA_RST_BYTE;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      wdrst_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      cmp_high_r <= cmp_high_nxt;
      offset_r <= offset_nxt;
      mod2_mode_r <= mod2_mode_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wdrst_r <= wdrst_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign counter_irq = irq_r;
  assign watchdog_reset = wdrst_r;

  // Shadow deadline for the checks below: counter clocks since the last refresh or reset,
  // so the compare-byte logic is judged against plain arithmetic rather than against itself.
  always_comb begin
    wd_ticks_nxt = tick ? wd_ticks_r + 17'h00001 : wd_ticks_r;
    wd_limit_nxt = wd_limit_r;
    // A hit or a disable ends the tracked period until the next refresh.
    wd_track_nxt = wd_track_r && wd_active && !wd_hit;
    if (wd_active && wr_cmp_high) begin
      wd_ticks_nxt = tick ? 17'h00001 : 17'h00000;
      wd_limit_nxt = {1'b0, offset_r, 8'h00} + 17'h00100 - {9'h000, cnt_r[7:0]};
      wd_track_nxt = 1'b1;
    end
  end

  // Shadow registers restart with the reset deadline of 256 counter clocks.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wd_ticks_r <= 17'h00000;
      wd_limit_r <= 17'(`CA_WD_DEFAULT_TICKS);
      wd_track_r <= 1'b1;
    end else begin
      wd_ticks_r <= wd_ticks_nxt;
      wd_limit_r <= wd_limit_nxt;
      wd_track_r <= wd_track_nxt;
    end
  end

  // Checks on the watchdog and register behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_force_write;
    wd_active && wr_ctrl && sfr_req.wdata[`CA_BIT_MODULE2_MATCH_FLAG];
  endsequence

  sequence s_refresh;
    wd_active && wr_cmp_high;
  endsequence

  sequence s_unlocked_disable;
    !mode_r.watchdog_lock_bit && wr_mode && !sfr_req.wdata[`CA_BIT_WATCHDOG_ENABLE_BIT] && !sfr_req.wdata[`CA_BIT_WATCHDOG_LOCK_BIT];
  endsequence

  // The tick that should carry the low byte over at the deadline.
  sequence s_last_tick;
    wd_track_r && tick && (wd_ticks_r == wd_limit_r - 17'h00001);
  endsequence

  a_hit_resets: assert property (wd_hit |=> watchdog_reset)
    else $error("Watchdog deadline passed without a reset pulse.");

  a_force_resets: assert property (s_force_write |=> watchdog_reset)
    else $error("Forced watchdog reset did not follow a flag write.");

  a_mode_frozen: assert property (wd_active && wr_mode
    |=> $stable(mode_r.cps) && $stable(mode_r.idle_suspend_bit))
    else $error("Clock select or idle suspend changed while the watchdog ran.");

  a_lock_sticks: assert property (mode_r.watchdog_lock_bit |=> mode_r.watchdog_lock_bit && wd_active)
    else $error("Lock bit cleared or watchdog dropped while locked.");

  a_unlock_disable: assert property (s_unlocked_disable |=> !wd_active ##1 !watchdog_reset)
    else $error("Watchdog stayed active after an unlocked disable.");

  a_idle_pause: assert property (wd_active && mode_r.idle_suspend_bit && cpu_idle |=> $stable(cnt_r))
    else $error("Counter moved during idle with suspend set.");

  a_wrap_flag: assert property (wrap |=> ctrl_r.cf)
    else $error("Counter wrap did not set the overflow flag.");

  a_stopped_count: assert property (!run && !sfr_req.wr |=> $stable(cnt_r))
    else $error("Counter moved while stopped.");

  a_rsvd_read: assert property (sfr_req.addr == `CA_ADDR_CTRL |=> sfr_rdata[5:3] == 3'h0)
    else $error("Reserved control bits read non-zero.");

  a_match_flag: assert property (module_match[0] |=> ctrl_r.ccf[0])
    else $error("Module 0 match did not set its flag.");

  a_refresh_load: assert property (s_refresh
    |=> cmp_high_r == 8'($past(cnt_r[15:8]) + $past(offset_r)))
    else $error("Refresh did not load counter high plus offset.");

  a_forced_run: assert property (wd_active && pre_tick && !(mode_r.idle_suspend_bit && cpu_idle)
    |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("Counter did not advance while the watchdog ran.");

  a_deadline_early: assert property (wd_track_r && wd_hit
    |-> wd_ticks_r == wd_limit_r - 17'h00001)
    else $error("Watchdog reset came before its deadline.");

  a_deadline_late: assert property (s_last_tick |-> wd_hit)
    else $error("Watchdog deadline passed without a hit.");

  a_reset_values: assert property ($rose(rst_b) |-> cnt_r == `CA_RST_CNT
    && offset_r == `CA_RST_BYTE && mode_r == mode_s'(`CA_RST_MODE))
    else $error("Watchdog state after reset is not the default.");

  a_pulse_cause: assert property (watchdog_reset |-> $past(wd_hit || wd_force))
    else $error("Watchdog reset pulse without a cause.");
endmodule

// file: core/counter_prescaler.sv
// Counter clock enable generator for the counter array.
// Assumes ext_tick is a one-cycle pulse synchronous to clk.
`include "counter_array_regs.svh"
module counter_prescaler #(
  parameter int DIV_SLOW = `CA_SYSDIV_SLOW
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Source selection.
  input wire logic [2:0] sel,
  input wire logic ext_tick,
  // Counter clock enable, one cycle wide.
  output logic tick
);
  logic [3:0] div_r;
  logic [3:0] div_nxt;

  // Free-running divider; the mid rate is taken from its low bits so one counter serves both.
  always_comb begin
    div_nxt = (div_r == 4'(DIV_SLOW - 1)) ? 4'h0 : div_r + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Source mux; unlisted codes fall back to the external tick.
  always_comb begin
    case (sel)
      `CA_CPS_DIV12: tick = (div_r == 4'(DIV_SLOW - 1));
      `CA_CPS_DIV4: tick = (div_r[1:0] == 2'h3);
      `CA_CPS_SYSTEM_CLOCK: tick = 1'b1;
      default: tick = ext_tick;
    endcase
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the counter array watchdog: reset values, freezes, lock, forced
// and timed resets, flags and counter run control, driven through the register port plus the match and idle inputs.
// Assumes the core files are compiled first and core/ is on the include path.
`include "counter_array_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import counter_array_pkg::*;
  // Divider shortened so the default timeout is 256 * 4 system clocks.
  localparam int DIV = 4;
  logic clk;
  logic rst_b;
  sfr_req_s sfr_req;
  logic [7:0] sfr_rdata;
  logic cpu_idle;
  logic ext_tick;
  logic [2:0] module_match;
  logic [2:0] module_int_en;
  logic counter_irq;
  logic watchdog_reset;
  int failures;
  int checks_done;
  logic [7:0] v;
  int n;

  counter_array_watchdog #(.DIV_SLOW(DIV)) u_dut (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .ext_tick(ext_tick),
    .module_match(module_match), .module_int_en(module_int_en),
    .counter_irq(counter_irq), .watchdog_reset(watchdog_reset));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // Inputs change only at the falling edge, so the rising edge sees them settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{addr: a, wr: 1'b1, wdata: d};
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_req.addr = a;
    @(negedge clk);
    d = sfr_rdata;
  endtask

  // Bounded wait for the reset pulse; a missing pulse that was required ends the run.
  task automatic wait_rst(input int bound, input bit must, output int cnt);
    cnt = 0;
    while (cnt < bound && watchdog_reset !== 1'b1) begin
      @(negedge clk);
      cnt++;
    end
    if (must && watchdog_reset !== 1'b1) begin
      chk1(1'b0, 1'b1, "reset pulse never came");
      final_report();
    end
  endtask

  // Plays the system reset controller: a short synchronous low pulse.
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
  endtask

  task automatic t_reset();
    rd(`CA_ADDR_CNT_LOW, v);
    chk8(v, 8'h00, "counter low reset");
    rd(`CA_ADDR_CMP_HIGH, v);
    chk8(v, 8'h00, "compare high reset");
    rd(`CA_ADDR_CTRL, v);
    chk8(v, 8'h00, "control reset");
    rd(`CA_ADDR_MODE, v);
    chk8(v, 8'h40, "mode reset");
    rd(`CA_ADDR_OFFSET, v);
    chk8(v, 8'h00, "offset reset");
    $display("test reset done");
  endtask

  task automatic t_timeout();
    do_reset();
    wait_rst(1200, 1'b1, n);
    chk1(n >= 256 * DIV - 2 && n <= 256 * DIV + 2, 1'b1, "default timeout");
    @(negedge clk);
    chk1(watchdog_reset, 1'b0, "pulse one cycle");
    do_reset();
    $display("test default timeout done");
  endtask

  task automatic t_freeze_force();
    wr(`CA_ADDR_MODE, 8'hCE);
    rd(`CA_ADDR_MODE, v);
    chk8(v, 8'h40, "select and idle frozen");
    wr(`CA_ADDR_MOD2_MODE, 8'h48);
    rd(`CA_ADDR_MOD2_MODE, v);
    chk8(v, 8'h00, "module 2 mode blocked");
    wr(`CA_ADDR_CTRL, 8'h04);
    wait_rst(3, 1'b1, n);
    chk1(watchdog_reset, 1'b1, "forced reset");
    do_reset();
    $display("test freeze and force done");
  endtask

  task automatic t_lock();
    wr(`CA_ADDR_MODE, 8'h20);
    wr(`CA_ADDR_MODE, 8'h00);
    rd(`CA_ADDR_MODE, v);
    chk8(v, 8'h20, "lock holds");
    wr(`CA_ADDR_CTRL, 8'h04);
    wait_rst(3, 1'b1, n);
    chk1(watchdog_reset, 1'b1, "locked watchdog still active");
    do_reset();
    rd(`CA_ADDR_MODE, v);
    chk8(v, 8'h40, "reset clears lock");
    $display("test lock done");
  endtask

  task automatic t_disabled();
    wr(`CA_ADDR_MODE, 8'h00);
    wr(`CA_ADDR_CTRL, 8'h04);
    wait_rst(600 * DIV, 1'b0, n);
    chk1(watchdog_reset, 1'b0, "disabled, no reset");
    rd(`CA_ADDR_CTRL, v);
    chk8(v, 8'h04, "flag 2 set by write");
    module_int_en = 3'b001;
    @(negedge clk);
    module_match = 3'b011;
    @(negedge clk);
    module_match = 3'b000;
    repeat (2) @(negedge clk);
    chk1(counter_irq, 1'b1, "match interrupt");
    rd(`CA_ADDR_CTRL, v);
    chk8(v, 8'h07, "match flags set");
    wr(`CA_ADDR_CTRL, 8'h38);
    rd(`CA_ADDR_CTRL, v);
    chk8(v, 8'h00, "flags cleared, bits 5:3 zero");
    wr(`CA_ADDR_MODE, 8'h09);
    wr(`CA_ADDR_CNT_LOW, 8'hFF);
    wr(`CA_ADDR_CNT_HIGH, 8'hFF);
    rd(`CA_ADDR_CNT_LOW, v);
    chk8(v, 8'hFF, "stopped counter written");
    wr(`CA_ADDR_CTRL, 8'h40);
    repeat (3) @(negedge clk);
    rd(`CA_ADDR_CTRL, v);
    chk8(v, 8'hC0, "overflow flag on wrap");
    chk1(counter_irq, 1'b1, "overflow interrupt");
    wr(`CA_ADDR_CTRL, 8'h00);
    rd(`CA_ADDR_CNT_LOW, v);
    n = v;
    repeat (5) @(negedge clk);
    rd(`CA_ADDR_CNT_LOW, v);
    chk8(v, n[7:0], "run bit 0 stops counter");
    $display("test disabled watchdog done");
  endtask

  task automatic t_refresh();
    wr(`CA_ADDR_MODE, 8'h00);
    wr(`CA_ADDR_MODE, 8'h02);
    wr(`CA_ADDR_OFFSET, 8'h02);
    wr(`CA_ADDR_CNT_LOW, 8'h00);
    wr(`CA_ADDR_CNT_HIGH, 8'h00);
    wr(`CA_ADDR_MODE, 8'h82);
    wr(`CA_ADDR_MODE, 8'hC2);
    wr(`CA_ADDR_CMP_HIGH, 8'hA5);
    rd(`CA_ADDR_CMP_HIGH, v);
    chk8(v, 8'h02, "refresh loads high plus offset");
    cpu_idle = 1'b1;
    rd(`CA_ADDR_CNT_LOW, v);
    n = v;
    repeat (8) @(negedge clk);
    rd(`CA_ADDR_CNT_LOW, v);
    chk8(v, n[7:0], "idle pauses counter");
    cpu_idle = 1'b0;
    repeat (3) begin
      wait_rst(1500, 1'b0, n);
      chk1(watchdog_reset, 1'b0, "refreshed in time");
      wr(`CA_ADDR_CMP_HIGH, 8'h00);
    end
    wait_rst(3300, 1'b1, n);
    chk1(n >= 2040 && n <= 3080, 1'b1, "offset timeout");
    do_reset();
    $display("test refresh done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence: reset held 20 cycles, then each scenario in turn.
  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    sfr_req = '{addr: 8'h00, wr: 1'b0, wdata: 8'h00};
    cpu_idle = 1'b0;
    ext_tick = 1'b0;
    module_match = 3'b000;
    module_int_en = 3'b000;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_timeout();
    t_freeze_force();
    t_lock();
    t_disabled();
    t_refresh();
    final_report();
  end
endmodule
